// ### hw/aap_regs.svh
// offsets, field positions, reset values and timing counts of the acl block
`ifndef AAP_REGS_SVH
`define AAP_REGS_SVH

// ==========================================================================
// direct register addresses
`define AAP_ADDR_IND_CTRL 8'h6E
`define AAP_ADDR_IND_OFS 8'h6F
`define AAP_ADDR_IND_DATA 8'hA0

// ==========================================================================
// indirect control fields
`define AAP_TBL_MSB 7
`define AAP_TBL_LSB 5
`define AAP_TBL_ACL 3'b010
`define AAP_PORT_MSB 3
`define AAP_PORT_LSB 0

// ==========================================================================
// indirect offsets inside the list table
`define AAP_OFS_PRIO_ACT 8'h0A
`define AAP_OFS_FWD_ACT 8'h0B
`define AAP_OFS_RS_HIGH 8'h0C
`define AAP_OFS_RS_LOW 8'h0D

// ==========================================================================
// priority action byte fields
`define AAP_PM_MSB 7
`define AAP_PM_LSB 6
`define AAP_PV_MSB 5
`define AAP_PV_LSB 3
`define AAP_RPE_BIT 2
`define AAP_RP_MSB 1
`define AAP_RP_LSB 0

// ==========================================================================
// forward map action byte fields
`define AAP_MM_MSB 6
`define AAP_MM_LSB 5
`define AAP_FWD_MSB 4
`define AAP_FWD_LSB 0
`define AAP_UNIT_BIT 4
`define AAP_CNTUP_BIT 3
`define AAP_FWD_VALID 5'h17

// ==========================================================================
// reset values
`define AAP_RST_PRIO_ACT 8'h00
`define AAP_RST_FWD_ACT 8'h00
`define AAP_RST_RS 8'h00
`define AAP_RST_IND 8'h00

// ==========================================================================
// timing
`define AAP_CLK_PERIOD_NS 40
`define AAP_US_NS 1000
`define AAP_US_CYC (`AAP_US_NS / `AAP_CLK_PERIOD_NS)
`define AAP_MS_US 1000

`endif

// ### hw/aap_pkg.sv
// types of the acl action processing block
package aap_pkg;

    // priority override mode encodings
    typedef enum logic [1:0] {
        AAP_PM_QOS = 2'b00,
        AAP_PM_HIGHER = 2'b01,
        AAP_PM_LOWER = 2'b10,
        AAP_PM_REPLACE = 2'b11
    } aap_prio_mode_t;

    // forwarding map merge mode encodings
    typedef enum logic [1:0] {
        AAP_MM_LOOKUP = 2'b00,
        AAP_MM_OR = 2'b01,
        AAP_MM_AND = 2'b10,
        AAP_MM_REPLACE = 2'b11
    } aap_map_mode_t;

    typedef logic [10:0] aap_cnt_t;

endpackage : aap_pkg

// ### hw/aap_action.sv
// acl action processing: priority, remark, map merge, counters, rule sets
`timescale 1ns/1ps
`include "aap_regs.svh"

module aap_action #(
    parameter int NPORT = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic [2*NPORT-1:0] matchTypeSel,
    input wire logic [2*NPORT-1:0] matchQualSel,
    input wire logic pktValid,
    input wire logic [1:0] pktPort,
    input wire logic pktHit,
    input wire logic pktTagged,
    input wire logic [2:0] qosPrio,
    input wire logic [2:0] pktVlanPrio,
    input wire logic [4:0] lookupMap,
    output logic outValid,
    output logic [2:0] outPrio,
    output logic [2:0] outVlanPrio,
    output logic [4:0] outMap,
    output logic [NPORT-1:0] cntExpire,
    output logic [16*NPORT-1:0] entryGroupMask
);
    import aap_pkg::*;

    // ======================================================================
    // direct and indirect register state
    logic [7:0] indCtrl_q;
    logic [7:0] indOfs_q;
    logic [7:0] regRdData_q;
    logic [NPORT-1:0][7:0] prioAct_q;
    logic [NPORT-1:0][7:0] fwdAct_q;
    logic [NPORT-1:0][7:0] rsHigh_q;
    logic [NPORT-1:0][7:0] rsLow_q;
    logic tblIsAcl;
    logic [3:0] portNib;
    logic portOk;
    logic [1:0] portIdx;
    logic dataWr;

    // indirect decode of the table and port select
    // table and port select
    assign tblIsAcl = indCtrl_q[`AAP_TBL_MSB:`AAP_TBL_LSB] == `AAP_TBL_ACL;
    assign portNib = indCtrl_q[`AAP_PORT_MSB:`AAP_PORT_LSB];
    assign portOk = tblIsAcl && portNib >= 4'h1 &&
                    portNib <= 4'(NPORT);
    assign portIdx = 2'(portNib - 4'h1);
    assign dataWr = regWrEn && regAddr == `AAP_ADDR_IND_DATA;

    // control and offset bytes of the indirect window
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            indCtrl_q <= `AAP_RST_IND;
            indOfs_q <= `AAP_RST_IND;
        end else if (regWrEn) begin
            if (regAddr == `AAP_ADDR_IND_CTRL) begin
                indCtrl_q <= regWrData;
            end
            if (regAddr == `AAP_ADDR_IND_OFS) begin
                indOfs_q <= regWrData;
            end
        end
    end

    // ======================================================================
    // microsecond and millisecond time base
    logic [7:0] usCnt_q;
    logic usTick_q;
    logic [9:0] msCnt_q;
    logic msTick_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            usCnt_q <= 8'h00;
            usTick_q <= 1'b0;
        end else if (usCnt_q == 8'(`AAP_US_CYC - 1)) begin
            usCnt_q <= 8'h00;
            usTick_q <= 1'b1;
        end else begin
            usCnt_q <= usCnt_q + 8'h01;
            usTick_q <= 1'b0;
        end
    end

    // millisecond tick from a thousand microsecond ticks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            msCnt_q <= 10'h000;
            msTick_q <= 1'b0;
        end else begin
            msTick_q <= 1'b0;
            if (usTick_q) begin
                if (msCnt_q == 10'(`AAP_MS_US - 1)) begin
                    msCnt_q <= 10'h000;
                    msTick_q <= 1'b1;
                end else begin
                    msCnt_q <= msCnt_q + 10'h001;
                end
            end
        end
    end

    // ======================================================================
    // per-port action bytes, rule-set mask and counter
    logic [NPORT-1:0] cntMode;
    logic [NPORT-1:0] cntExp_q;

    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            logic wrSel;
            aap_cnt_t cnt_q;
            aap_cnt_t limit;
            logic cntRun_q;
            logic tick;
            logic pktMatch;

            assign wrSel = dataWr && portOk && portIdx == 2'(p);

            // indirect byte storage of this port
            // action and rule-set bytes
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    prioAct_q[p] <= `AAP_RST_PRIO_ACT;
                    fwdAct_q[p] <= `AAP_RST_FWD_ACT;
                    rsHigh_q[p] <= `AAP_RST_RS;
                    rsLow_q[p] <= `AAP_RST_RS;
                end else if (wrSel) begin
                    unique case (indOfs_q)
                        `AAP_OFS_PRIO_ACT: prioAct_q[p] <= regWrData;
                        `AAP_OFS_FWD_ACT: fwdAct_q[p] <= regWrData;
                        `AAP_OFS_RS_HIGH: rsHigh_q[p] <= regWrData;
                        `AAP_OFS_RS_LOW: rsLow_q[p] <= regWrData;
                        default: ;
                    endcase
                end
            end

            assign entryGroupMask[16*p +: 16] = {rsHigh_q[p], rsLow_q[p]};

            // counting setup: match type 01 with qualifier 00
            // counting selection
            assign cntMode[p] = matchTypeSel[2*p +: 2] == 2'b01 &&
                                matchQualSel[2*p +: 2] == 2'b00;
            // limit is the action fields pm, p, rpe, rp and mm in order
            assign limit = {1'b0, prioAct_q[p],
                            fwdAct_q[p][`AAP_MM_MSB:`AAP_MM_LSB]};
            assign tick = fwdAct_q[p][`AAP_UNIT_BIT] ? msTick_q : usTick_q;
            assign pktMatch = pktValid && pktHit && pktPort == 2'(p);

            // eleven-bit counter, down on time or up on packets
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    cnt_q <= 11'h000;
                    cntRun_q <= 1'b0;
                    cntExp_q[p] <= 1'b0;
                end else begin
                    cntExp_q[p] <= 1'b0;
                    cntRun_q <= cntMode[p];
                    if (!cntMode[p]) begin
                        cnt_q <= 11'h000;
                    end else if (!fwdAct_q[p][`AAP_CNTUP_BIT]) begin
                        if (!cntRun_q) begin
                            cnt_q <= limit;
                        end else if (tick) begin
                            if (cnt_q == 11'h000) begin
                                cntExp_q[p] <= 1'b1;
                                cnt_q <= limit;
                            end else begin
                                cnt_q <= cnt_q - 11'h001;
                            end
                        end
                    end else begin
                        if (!cntRun_q) begin
                            cnt_q <= 11'h000;
                        end else if (pktMatch) begin
                            if (cnt_q + 11'h001 >= limit) begin
                                cntExp_q[p] <= 1'b1;
                                cnt_q <= 11'h000;
                            end else begin
                                cnt_q <= cnt_q + 11'h001;
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    assign cntExpire = cntExp_q;

    // ======================================================================
    // host read path, one cycle after the read strobe
    logic [7:0] indRd;

    // selected indirect byte, zero for unknown offsets or ports
    always_comb begin
        indRd = 8'h00;
        if (portOk) begin
            unique case (indOfs_q)
                `AAP_OFS_PRIO_ACT: indRd = prioAct_q[portIdx];
                `AAP_OFS_FWD_ACT: indRd = fwdAct_q[portIdx];
                `AAP_OFS_RS_HIGH: indRd = rsHigh_q[portIdx];
                `AAP_OFS_RS_LOW: indRd = rsLow_q[portIdx];
                default: indRd = 8'h00;
            endcase
        end
    end

    // registered read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData_q <= 8'h00;
        end else if (regRdEn) begin
            unique case (regAddr)
                `AAP_ADDR_IND_CTRL: regRdData_q <= indCtrl_q;
                `AAP_ADDR_IND_OFS: regRdData_q <= indOfs_q;
                `AAP_ADDR_IND_DATA: regRdData_q <= indRd;
                default: regRdData_q <= 8'h00;
            endcase
        end
    end

    assign regRdData = regRdData_q;

    // ======================================================================
    // packet action path
    logic [7:0] pa;
    logic [7:0] fa;
    aap_prio_mode_t pm;
    aap_map_mode_t mm;
    logic [2:0] pv;
    logic [4:0] am;
    logic act;
    logic [2:0] prio_d;
    logic [2:0] vlan_d;
    logic [4:0] map_d;

    assign pa = prioAct_q[pktPort];
    assign fa = fwdAct_q[pktPort];
    assign pm = aap_prio_mode_t'(pa[`AAP_PM_MSB:`AAP_PM_LSB]);
    assign pv = pa[`AAP_PV_MSB:`AAP_PV_LSB];
    assign mm = aap_map_mode_t'(fa[`AAP_MM_MSB:`AAP_MM_LSB]);
    assign am = fa[`AAP_FWD_MSB:`AAP_FWD_LSB] & `AAP_FWD_VALID;
    assign act = pktHit && !cntMode[pktPort];

    // priority override of tagged packets
    always_comb begin
        prio_d = qosPrio;
        if (act && pktTagged) begin
            unique case (pm)
                AAP_PM_QOS: prio_d = qosPrio;
                AAP_PM_HIGHER: prio_d = (pv > qosPrio) ? pv : qosPrio;
                AAP_PM_LOWER: prio_d = (pv < qosPrio) ? pv : qosPrio;
                AAP_PM_REPLACE: prio_d = pv;
            endcase
        end
    end

    // vlan priority remark
    // remark on enable
    assign vlan_d = (act && pa[`AAP_RPE_BIT]) ?
                    {1'b0, pa[`AAP_RP_MSB:`AAP_RP_LSB]} : pktVlanPrio;

    // forwarding map merge
    always_comb begin
        map_d = lookupMap;
        if (act) begin
            unique case (mm)
                AAP_MM_LOOKUP: map_d = lookupMap;
                AAP_MM_OR: map_d = am | lookupMap;
                AAP_MM_AND: map_d = am & lookupMap;
                AAP_MM_REPLACE: map_d = am;
            endcase
        end
    end

    logic outValid_q;
    logic [2:0] outPrio_q;
    logic [2:0] outVlan_q;
    logic [4:0] outMap_q;

    // result register, one cycle after the packet is presented
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outValid_q <= 1'b0;
            outPrio_q <= 3'h0;
            outVlan_q <= 3'h0;
            outMap_q <= 5'h00;
        end else begin
            outValid_q <= pktValid;
            if (pktValid) begin
                outPrio_q <= prio_d;
                outVlan_q <= vlan_d;
                outMap_q <= map_d;
            end
        end
    end

    assign outValid = outValid_q;
    assign outPrio = outPrio_q;
    assign outVlanPrio = outVlan_q;
    assign outMap = outMap_q;

endmodule : aap_action

// ### tb/aap_action_checker.sv
// concurrent checks on the ports of the acl action block
`timescale 1ns/1ps
module aap_action_checker #(
    parameter int NPORT = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic [2*NPORT-1:0] matchTypeSel,
    input wire logic [2*NPORT-1:0] matchQualSel,
    input wire logic pktValid,
    input wire logic [1:0] pktPort,
    input wire logic pktHit,
    input wire logic pktTagged,
    input wire logic [2:0] qosPrio,
    input wire logic [2:0] pktVlanPrio,
    input wire logic [4:0] lookupMap,
    input wire logic outValid,
    input wire logic [2:0] outPrio,
    input wire logic [2:0] outVlanPrio,
    input wire logic [4:0] outMap,
    input wire logic [NPORT-1:0] cntExpire,
    input wire logic [16*NPORT-1:0] entryGroupMask
);
    // port 1 is in counting setup
    logic cnt0;
    assign cnt0 = matchTypeSel[1:0] == 2'b01 && matchQualSel[1:0] == 2'b00;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // packet path
    a_out_follows: assert property (pktValid |=> outValid)
        else $error("no result after packet request");
    a_out_cause: assert property (outValid |-> $past(pktValid))
        else $error("result without packet request");
    a_miss_passes: assert property (pktValid && !pktHit |=>
        outPrio == $past(qosPrio) && outMap == $past(lookupMap)
        && outVlanPrio == $past(pktVlanPrio))
        else $error("missed packet was altered");
    a_untagged_prio: assert property (pktValid && !pktTagged |=>
        outPrio == $past(qosPrio))
        else $error("untagged packet priority changed");
    a_map_reserved: assert property (pktValid && !lookupMap[3] |=>
        !outMap[3])
        else $error("reserved map bit forwarded");
    a_count_no_action: assert property (pktValid && pktPort == 2'd0
        && cnt0 |=> outPrio == $past(qosPrio) && outMap == $past(lookupMap))
        else $error("counting entry applied actions");
    a_expire_counting: assert property (cntExpire[0] |-> $past(cnt0))
        else $error("expiry outside counting setup");

    // ==========================================================
    // register window
    a_rd_holds: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (regRdEn
        && !(regAddr inside {8'h6E, 8'h6F, 8'hA0}) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_mask_source: assert property ($changed(entryGroupMask) |->
        $past(regWrEn) && $past(regAddr) == 8'hA0)
        else $error("group mask changed without data write");

    c_expire: cover property (cntExpire[0]);
    c_tag_hit: cover property (pktValid && pktHit && pktTagged);
    c_data_read: cover property (regRdEn && regAddr == 8'hA0);
endmodule : aap_action_checker

bind aap_action aap_action_checker #(.NPORT(NPORT)) i_aap_action_checker (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .matchTypeSel(matchTypeSel),
    .matchQualSel(matchQualSel), .pktValid(pktValid), .pktPort(pktPort),
    .pktHit(pktHit), .pktTagged(pktTagged), .qosPrio(qosPrio),
    .pktVlanPrio(pktVlanPrio), .lookupMap(lookupMap), .outValid(outValid),
    .outPrio(outPrio), .outVlanPrio(outVlanPrio), .outMap(outMap),
    .cntExpire(cntExpire), .entryGroupMask(entryGroupMask));

// ### tb/aap_host_model.sv
// host model driving the indirect byte register window
`timescale 1ns/1ps
`include "aap_regs.svh"
module aap_host_model (
    input wire logic clk,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [7:0] regRdData
);
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end

    // one byte write; lines scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr

    // one byte read, data taken mid-cycle once it has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        @(negedge clk);
        d = regRdData;
    endtask : rd

    task automatic sel(input int port, input logic [7:0] ofs);
        wr(`AAP_ADDR_IND_CTRL, {`AAP_TBL_ACL, 1'b0, 4'(port)});
        wr(`AAP_ADDR_IND_OFS, ofs);
    endtask : sel

    task automatic iwr(input int port, input logic [7:0] ofs,
                       input logic [7:0] d);
        sel(port, ofs);
        wr(`AAP_ADDR_IND_DATA, d);
    endtask : iwr

    task automatic ird(input int port, input logic [7:0] ofs,
                       output logic [7:0] d);
        sel(port, ofs);
        rd(`AAP_ADDR_IND_DATA, d);
    endtask : ird
endmodule : aap_host_model

// ### tb/aap_action_tb.sv
// self-checking bench for the acl action block
`timescale 1ns/1ps
module aap_action_tb;
    import aap_pkg::*;
    logic clk, rst_n, regWrEn, regRdEn, pktValid, pktHit, pktTagged, outValid;
    logic [7:0] regAddr, regWrData, regRdData, matchTypeSel, matchQualSel, d;
    logic [1:0] pktPort;
    logic [2:0] qosPrio, pktVlanPrio, outPrio, outVlanPrio;
    logic [4:0] lookupMap, outMap;
    logic [3:0] cntExpire;
    logic [63:0] entryGroupMask;
    logic [7:0] mem [4][4];
    int errCount, checks, cyc, pulses, lastAt, gap;

    aap_host_model i_aap_host_model (.clk(clk), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData));
    aap_action #(.NPORT(4)) i_aap_action (.clk(clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .matchTypeSel(matchTypeSel),
        .matchQualSel(matchQualSel), .pktValid(pktValid), .pktPort(pktPort),
        .pktHit(pktHit), .pktTagged(pktTagged), .qosPrio(qosPrio),
        .pktVlanPrio(pktVlanPrio), .lookupMap(lookupMap), .outValid(outValid),
        .outPrio(outPrio), .outVlanPrio(outVlanPrio), .outMap(outMap),
        .cntExpire(cntExpire), .entryGroupMask(entryGroupMask));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // cycle count, hang limit and expiry pulse spacing
    always @(posedge clk) begin
        cyc++;
        if (rst_n && cntExpire[0] === 1'b1) begin
            gap = cyc - lastAt;
            lastAt = cyc;
            pulses++;
        end
        if (cyc == 80000) begin
            errCount++;
            close_out();
        end
    end

    task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    task automatic put(input int p, input int o, input logic [7:0] v);
        mem[p][o] = v;
        i_aap_host_model.iwr(p + 1, 8'h0A + 8'(o), v);
    endtask : put

    // one random packet on a non-counting port, checked against the model
    task automatic pkt(input int p);
        logic h, t;
        logic [2:0] q, v, ep, ev, ap;
        logic [4:0] lk, am, em;
        h = 1'($urandom);
        t = 1'($urandom);
        q = 3'($urandom);
        v = 3'($urandom);
        lk = 5'($urandom);
        ap = mem[p][0][5:3];
        am = mem[p][1][4:0] & 5'h17;
        ep = q;
        ev = v;
        em = lk;
        if (h) begin
            if (t) begin
                case (mem[p][0][7:6])
                    2'b01: if (ap > q) ep = ap;
                    2'b10: if (ap < q) ep = ap;
                    2'b11: ep = ap;
                    default: ;
                endcase
            end
            if (mem[p][0][2]) ev = {1'b0, mem[p][0][1:0]};
            case (mem[p][1][6:5])
                2'b01: em = am | lk;
                2'b10: em = am & lk;
                2'b11: em = am;
                default: ;
            endcase
        end
        @(posedge clk);
        pktValid <= 1'b1;
        pktPort <= 2'(p);
        pktHit <= h;
        pktTagged <= t;
        qosPrio <= q;
        pktVlanPrio <= v;
        lookupMap <= lk;
        @(posedge clk);
        pktValid <= 1'b0;
        @(negedge clk);
        chk("outValid", outValid, 1'b1);
        chk("outPrio", outPrio, ep);
        chk("outVlanPrio", outVlanPrio, ev);
        chk("outMap", outMap, em);
    endtask : pkt

    // back-to-back matched packets on port 1, results held in a queue
    task automatic burst(input int n);
        logic [7:0] pend [$];
        logic [7:0] e;
        for (int i = 0; i <= n; i++) begin
            @(posedge clk);
            pktValid <= (i < n);
            if (i < n) begin
                e = 8'($urandom);
                pend.push_back(e);
                pktPort <= 2'd0;
                pktHit <= 1'b1;
                qosPrio <= e[7:5];
                lookupMap <= e[4:0];
            end
            @(negedge clk);
            if (i > 0) begin
                e = pend.pop_front();
                chk("cntPrio", outPrio, e[7:5]);
                chk("cntMap", outMap, e[4:0]);
            end
        end
        repeat (3) @(posedge clk);
    endtask : burst

    initial begin
        rst_n = 1'b0;
        {pktValid, pktHit, pktTagged, pktPort} = '0;
        {qosPrio, pktVlanPrio, lookupMap} = '0;
        matchTypeSel = 8'h00;
        matchQualSel = 8'h00;
        void'($urandom(32'hc8b0_2dfa));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // every action byte starts at zero
        for (int p = 0; p < 4; p++) begin
            for (int o = 0; o < 4; o++) begin
                i_aap_host_model.ird(p + 1, 8'h0A + 8'(o), d);
                chk("resetByte", d, 8'h00);
            end
        end
        for (int p = 0; p < 16; p++) put(p / 4, p % 4, 8'($urandom));
        for (int p = 0; p < 16; p++) begin
            i_aap_host_model.ird(p / 4 + 1, 8'h0A + 8'(p % 4), d);
            chk("readBack", d, mem[p / 4][p % 4]);
        end
        for (int p = 0; p < 4; p++) begin
            chk("groupMask", entryGroupMask[16*p+:16],
                {mem[p][2], mem[p][3]});
        end
        i_aap_host_model.rd(8'h55, d);
        chk("unmapped", d, 8'h00);
        i_aap_host_model.wr(8'h6E, 8'h21);
        i_aap_host_model.wr(8'hA0, ~mem[0][3]);
        i_aap_host_model.ird(1, 8'h0D, d);
        chk("wrongTable", d, mem[0][3]);
        // every priority mode with every map mode
        for (int m = 0; m < 16; m++) begin
            put(m % 4, 0, {2'(m / 4), 6'($urandom)});
            put(m % 4, 1, {1'b0, 2'(m), 5'($urandom)});
            repeat (6) pkt(m % 4);
        end
        // count matched packets up to a limit of three
        put(0, 0, 8'h00);
        put(0, 1, 8'h68);
        matchQualSel <= {6'($urandom), 2'b00};
        matchTypeSel <= 8'h01;
        pulses = 0;
        burst(2);
        chk("upPulses", pulses, 0);
        burst(1);
        chk("upPulses", pulses, 1);
        burst(3);
        chk("upPulses", pulses, 2);
        // count down, microsecond ticks, limit three
        matchTypeSel <= 8'h00;
        put(0, 1, 8'h60);
        matchTypeSel <= 8'h01;
        pulses = 0;
        for (int w = 0; w < 400 && pulses < 3; w++) @(posedge clk);
        chk("usGap", gap, 100);
        matchTypeSel <= 8'h00;
        put(0, 1, 8'h10);
        matchTypeSel <= 8'h01;
        pulses = 0;
        for (int w = 0; w < 52000 && pulses < 2; w++) @(posedge clk);
        chk("msGap", gap, 25000);
        close_out();
    end
endmodule : aap_action_tb
